// ### sdram_cfg_pkg.sv
// Purpose: Shared constants and types for the DRAM command front end
// Assumes: Single clock, commands sampled on the rising edge
// Notes:   Mode value layout, command codes and timing counts live here
package sdram_cfg_pkg;
   localparam int ROW_W  = 13;
   localparam int COL_W  = 9;
   localparam int BANK_W = 2;
   localparam int MODE_W = 12;

   // Mode field positions
   localparam int BL_LSB  = 0;
   localparam int BT_BIT  = 3;
   localparam int CL_LSB  = 4;
   localparam int OPM_LSB = 7;
   localparam int WBM_BIT = 9;
   // Address bit that widens a precharge to every bank
   localparam int ALL_BANK_BIT = 10;

   // Burst length codes
   localparam logic [2:0] BL_ONE  = 3'h0;
   localparam logic [2:0] BL_TWO  = 3'h1;
   localparam logic [2:0] BL_FOUR = 3'h2;
   localparam logic [2:0] BL_EIGHT = 3'h3;
   localparam logic [2:0] BL_ROW  = 3'h7;
   // Latency codes
   localparam logic [2:0] CL_TWO   = 3'h2;
   localparam logic [2:0] CL_THREE = 3'h3;
   localparam logic [1:0] OPM_NORMAL = 2'h0;

   localparam logic [8:0] BURST_ONE_LEN   = 9'h001;
   localparam logic [8:0] BURST_TWO_LEN   = 9'h002;
   localparam logic [8:0] BURST_FOUR_LEN  = 9'h004;
   localparam logic [8:0] BURST_EIGHT_LEN = 9'h008;
   localparam logic [COL_W-1:0] COL_ZERO  = 9'h000;
   localparam logic [COL_W-1:0] COL_ONE   = 9'h001;

   // Power-up wait
   localparam int  CLK_MHZ       = 200;
   localparam int  PWRUP_US      = 100;
   localparam int  PWRUP_CYC     = PWRUP_US * CLK_MHZ;
   localparam int  REFRESH_NEEDED = 2;
   localparam logic [2:0] LAT_ONE = 3'h1;

   // Command code {cs_n, ras_n, cas_n, we_n}
   typedef enum logic [3:0] {
      CMD_DESELECT  = 4'h8,
      CMD_MODE_LOAD = 4'h0,
      CMD_REFRESH   = 4'h1,
      CMD_PRECHARGE = 4'h2,
      CMD_ROW_OPEN  = 4'h3,
      CMD_WRITE     = 4'h4,
      CMD_READ      = 4'h5,
      CMD_STOP      = 4'h6,
      CMD_NOP       = 4'h7
   } cmd_t;

   typedef enum logic [2:0] {
      ST_POWER_WAIT = 3'b000,
      ST_NEED_PRE   = 3'b001,
      ST_NEED_REF   = 3'b010,
      ST_NEED_MODE  = 3'b011,
      ST_READY      = 3'b100
   } init_t;

   // Command and address bundle
   typedef struct packed {
      logic              cs_n;
      logic              ras_n;
      logic              cas_n;
      logic              we_n;
      logic [BANK_W-1:0] bank;
      logic [ROW_W-1:0]  addr;
   } cmd_bus_t;

   // Column stepping inputs
   typedef struct packed {
      logic [2:0]       len_code;
      logic             interleave;
      logic [COL_W-1:0] start_col;
      logic [COL_W-1:0] step;
   } col_req_t;
endpackage

// ### burst_col_gen.sv
// Purpose: Column address of the k-th access in a burst
// Assumes: Start column and step index given; purely combinational
// Notes:   Upper column bits outside the block always come from the start
`timescale 1ns/1ps
module burst_col_gen
   import sdram_cfg_pkg::*;
(
   input  sdram_cfg_pkg::col_req_t req,
   output logic [sdram_cfg_pkg::COL_W-1:0] col
);
   logic [COL_W-1:0] mask;
   logic [COL_W-1:0] seq;
   logic [COL_W-1:0] ilv;

   // Block mask from burst length; whole row uses all column bits
   always_comb begin
      case (req.len_code)
         BL_TWO:   mask = BURST_TWO_LEN - COL_ONE;   // [R14]
         BL_FOUR:  mask = BURST_FOUR_LEN - COL_ONE;  // [R14]
         BL_EIGHT: mask = BURST_EIGHT_LEN - COL_ONE; // [R14]
         BL_ROW:   mask = {COL_W{1'b1}};             // [R15]
         default:  mask = COL_ZERO;                  // [R24]
      endcase
   end

   // Sum wraps inside the block; row bursts wrap at the row end
   assign seq = (req.start_col + req.step) & mask;   // [R25] [R15]
   assign ilv = (req.start_col ^ req.step) & mask;   // [R25]

   // Interleave only for fixed lengths; the order bit is ignored for row bursts
   always_comb begin
      if (req.interleave && req.len_code != BL_ROW) begin // [R16] [R12]
         col = (req.start_col & ~mask) | ilv;
      end else begin
         col = (req.start_col & ~mask) | seq;              // [R14]
      end
   end
endmodule // burst_col_gen

// ### sdram_cmd_front.sv
// Purpose: Command decode, mode storage, burst column and read timing
// Assumes: Controller drives commands on core_clk rising edge
// Notes:   Pins pass a three-stage filter, so internal timing trails the pins
//
// Notes on behaviour
// R1 - Row open captures bank and row
// R2 - Column command takes start column bits
// R3 - Controller waits power-up time with idle commands
// R4 - Idle commands cover end of wait
// R5 - Precharge all banks after wait
// R6 - Two refreshes before mode load
// R7 - Mode undefined until first load
// R8 - Mode value held until reloaded
// R9 - Mode fields in fixed bit positions
// R10 - Top address bit low during load
// R11 - Load only when idle, then wait
// R12 - Lengths 1,2,4,8 both orders; row sequential
// R13 - Row burst cut by stop command
// R14 - Burst wraps within aligned block
// R15 - Row burst wraps to first column
// R16 - Order bit selects sequential or interleaved
// R17 - Read latency two or three cycles
// R18 - Output drive starts one cycle before data
// R19 - Only zero operating mode is normal
// R20 - Controller avoids reserved codes
// R21 - New column accepted every cycle; the pin filter only takes a command held at least two cycles
// R22 - Mode load delay before next command
// R23 - Write burst bit forces single writes
// R24 - Length one: single column, order ignored
// R25 - Interleave XOR, sequential add modulo block
// R26 - Customary length and latency encodings
`timescale 1ns/1ps
module sdram_cmd_front
   import sdram_cfg_pkg::*;
#(
   parameter int PWRUP_CYCLES = PWRUP_CYC
)(
   input  logic                           core_clk,
   input  logic                           rst_n,
   input  sdram_cfg_pkg::cmd_bus_t        cmd_pins,
   output logic [sdram_cfg_pkg::BANK_W-1:0] access_bank_ff,
   output logic [sdram_cfg_pkg::ROW_W-1:0]  access_row_ff,
   output logic [sdram_cfg_pkg::COL_W-1:0]  access_col_ff,
   output logic                           access_valid_ff,
   output logic                           access_write_ff,
   output logic                           dq_drive_ff,
   output logic                           rd_data_valid_ff,
   output logic [sdram_cfg_pkg::MODE_W-1:0] mode_value_ff,
   output logic                           mode_valid_ff,
   output logic                           mode_reserved_ff,
   output logic                           init_done_ff,
   output logic                           seq_error_ff
);
   localparam int PW = $clog2(PWRUP_CYCLES + 1);
   localparam logic [PW-1:0] PW_LAST = PW'(PWRUP_CYCLES);
   localparam logic [1:0] REF_LAST = 2'(REFRESH_NEEDED);
   localparam int LAT_DEPTH = 4;

   cmd_bus_t s1_ff, s2_ff, s3_ff, cmd_ff;
   logic     take_ff;
   logic [1:0] data_tap;
   logic [1:0] drive_tap;
   init_t    init_ff, nxt_init;
   logic [PW-1:0] pw_cnt_ff;
   logic          idle_seen_ff;
   logic [1:0]    ref_cnt_ff;
   logic [ROW_W-1:0]  open_row_ff [2**BANK_W];
   logic [2**BANK_W-1:0] bank_open_ff;
   logic              burst_on_ff;
   logic              burst_wr_ff;
   logic [BANK_W-1:0] burst_bank_ff;
   logic [COL_W-1:0]  burst_start_ff;
   logic [COL_W-1:0]  burst_step_ff;
   logic [COL_W-1:0]  burst_left_ff;
   logic [LAT_DEPTH-1:0] rd_pipe_ff;
   logic [COL_W-1:0]  gen_col;
   col_req_t          creq;
   cmd_t              cmd;
   logic [COL_W-1:0]  len_cols;
   logic [2:0]        lat;

   // Length in columns for a length code; zero for reserved
   function automatic logic [COL_W-1:0] len_of(input logic [2:0] code);
      case (code)
         BL_ONE:   len_of = BURST_ONE_LEN;     // [R26]
         BL_TWO:   len_of = BURST_TWO_LEN;     // [R26]
         BL_FOUR:  len_of = BURST_FOUR_LEN;    // [R26]
         BL_EIGHT: len_of = BURST_EIGHT_LEN;   // [R26]
         BL_ROW:   len_of = {COL_W{1'b1}};     // Runs until stopped
         default:  len_of = COL_ZERO;
      endcase
   endfunction

   // Three-stage pin filter; a change counts when stages two and three agree
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff  <= '1;
         s2_ff  <= '1;
         s3_ff  <= '1;
         cmd_ff <= '1;
         take_ff <= 1'b0;
      end else begin
         s1_ff <= cmd_pins;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         // One strobe per new pin value; a command held for many cycles acts once
         take_ff <= (s2_ff == s3_ff) && (s3_ff != cmd_ff);
         if (s2_ff == s3_ff) begin
            cmd_ff <= s3_ff;
         end
      end
   end

   // Deselect dominates; between strobes the bus reads as deselect
   always_comb begin
      if (!take_ff || cmd_ff.cs_n) begin
         cmd = CMD_DESELECT;
      end else begin
         cmd = cmd_t'({1'b0, cmd_ff.ras_n, cmd_ff.cas_n, cmd_ff.we_n});
      end
   end

   // Power-up wait counter and idle-command witness
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pw_cnt_ff    <= '0;
         idle_seen_ff <= 1'b0;
      end else if (init_ff == ST_POWER_WAIT) begin
         if (pw_cnt_ff != PW_LAST) begin
            pw_cnt_ff <= pw_cnt_ff + 1'b1;                       // [R3]
         end
         if (take_ff && (cmd == CMD_NOP || cmd == CMD_DESELECT)) begin
            idle_seen_ff <= 1'b1;                                // [R4]
         end
      end
   end

   // Initialization tracker; the device only observes the sequence
   always_comb begin
      nxt_init = init_ff;
      case (init_ff)
         ST_POWER_WAIT: begin
            if (pw_cnt_ff == PW_LAST && idle_seen_ff) begin      // [R3] [R4]
               nxt_init = ST_NEED_PRE;
            end
         end
         ST_NEED_PRE: begin
            if (cmd == CMD_PRECHARGE && cmd_ff.addr[ALL_BANK_BIT]) begin // [R5]
               nxt_init = ST_NEED_REF;
            end
         end
         ST_NEED_REF: begin
            if (cmd == CMD_REFRESH && ref_cnt_ff == REF_LAST - 2'h1) begin // [R6]
               nxt_init = ST_NEED_MODE;
            end
         end
         ST_NEED_MODE: begin
            if (cmd == CMD_MODE_LOAD) begin                      // [R7]
               nxt_init = ST_READY;
            end
         end
         ST_READY: nxt_init = ST_READY;
         default:  nxt_init = ST_POWER_WAIT;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         init_ff    <= ST_POWER_WAIT;
         ref_cnt_ff <= '0;
      end else begin
         init_ff <= nxt_init;
         if (init_ff == ST_NEED_REF && cmd == CMD_REFRESH) begin
            ref_cnt_ff <= ref_cnt_ff + 2'h1;                     // [R6]
         end
      end
   end

   // Mode register: loaded only by the load command, otherwise held
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_value_ff <= '0;
         mode_valid_ff <= 1'b0;
      end else if (cmd == CMD_MODE_LOAD && bank_open_ff == '0 && !burst_on_ff) begin // [R11]
         mode_value_ff <= cmd_ff.addr[MODE_W-1:0];               // [R8] [R10]
         mode_valid_ff <= 1'b1;                                  // [R7]
      end
   end

   // Field decode of the stored mode
   assign lat = mode_value_ff[CL_LSB +: 3];                      // [R9] [R17]
   assign len_cols = len_of(mode_value_ff[BL_LSB +: 3]);         // [R9] [R12]

   // Reserved or unsupported mode codes are flagged for software
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_reserved_ff <= 1'b0;
      end else begin
         mode_reserved_ff <= mode_valid_ff &&
            ((len_cols == COL_ZERO) ||                                         // [R20]
             (lat != CL_TWO && lat != CL_THREE) ||                            // [R17]
             (mode_value_ff[OPM_LSB +: 2] != OPM_NORMAL) ||                   // [R19]
             (mode_value_ff[BL_LSB +: 3] == BL_ROW && mode_value_ff[BT_BIT])); // [R12]
      end
   end

   // Out-of-order commands: non-idle command in power wait, row open or column command before ready, load while a row is open
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         seq_error_ff <= 1'b0;
         init_done_ff <= 1'b0;
      end else begin
         init_done_ff <= (init_ff == ST_READY);
         if ((init_ff == ST_POWER_WAIT && cmd != CMD_NOP && cmd != CMD_DESELECT) || // [R3]
             (init_ff != ST_READY && (cmd == CMD_ROW_OPEN || cmd == CMD_READ ||
                                      cmd == CMD_WRITE)) ||                         // [R7]
             (cmd == CMD_MODE_LOAD && bank_open_ff != '0)) begin                  // [R11]
            seq_error_ff <= 1'b1;
         end
      end
   end

   // Row open: bank and row captured per bank; precharge closes
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bank_open_ff <= '0;
         for (int b = 0; b < 2**BANK_W; b++) begin
            open_row_ff[b] <= '0;
         end
      end else if (cmd == CMD_ROW_OPEN) begin
         open_row_ff[cmd_ff.bank]  <= cmd_ff.addr;               // [R1]
         bank_open_ff[cmd_ff.bank] <= 1'b1;                      // [R1]
      end else if (cmd == CMD_PRECHARGE) begin
         if (cmd_ff.addr[ALL_BANK_BIT]) begin
            bank_open_ff <= '0;                                  // [R5]
         end else begin
            bank_open_ff[cmd_ff.bank] <= 1'b0;
         end
      end
   end

   // Burst engine; a new column command restarts at once
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         burst_on_ff    <= 1'b0;
         burst_wr_ff    <= 1'b0;
         burst_bank_ff  <= '0;
         burst_start_ff <= '0;
         burst_step_ff  <= '0;
         burst_left_ff  <= '0;
      end else if ((cmd == CMD_READ || cmd == CMD_WRITE) && bank_open_ff[cmd_ff.bank]) begin
         burst_on_ff    <= 1'b1;                                 // [R21]
         burst_wr_ff    <= (cmd == CMD_WRITE);
         burst_bank_ff  <= cmd_ff.bank;
         burst_start_ff <= cmd_ff.addr[COL_W-1:0];               // [R2]
         burst_step_ff  <= '0;
         if (cmd == CMD_WRITE && mode_value_ff[WBM_BIT]) begin
            burst_left_ff <= BURST_ONE_LEN;                      // [R23]
         end else begin
            burst_left_ff <= len_cols;                           // [R12]
         end
      end else if (cmd == CMD_STOP || cmd == CMD_PRECHARGE) begin
         burst_on_ff <= 1'b0;                                    // [R13]
      end else if (burst_on_ff) begin
         burst_step_ff <= burst_step_ff + COL_ONE;
         if (mode_value_ff[BL_LSB +: 3] != BL_ROW || burst_wr_ff && mode_value_ff[WBM_BIT]) begin
            burst_left_ff <= burst_left_ff - COL_ONE;
            if (burst_left_ff <= COL_ONE) begin
               burst_on_ff <= 1'b0;
            end
         end
      end
   end

   assign creq.len_code   = (burst_wr_ff && mode_value_ff[WBM_BIT]) ? BL_ONE
                                                                     : mode_value_ff[BL_LSB +: 3];
   assign creq.interleave = mode_value_ff[BT_BIT];               // [R16]
   assign creq.start_col  = burst_start_ff;
   assign creq.step       = burst_step_ff;

   burst_col_gen u_col (
      .req (creq),
      .col (gen_col)
   );

   // Array access presented one cycle per column
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         access_valid_ff <= 1'b0;
         access_write_ff <= 1'b0;
         access_bank_ff  <= '0;
         access_row_ff   <= '0;
         access_col_ff   <= '0;
      end else begin
         access_valid_ff <= burst_on_ff;
         access_write_ff <= burst_wr_ff;
         access_bank_ff  <= burst_bank_ff;
         access_row_ff   <= open_row_ff[burst_bank_ff];          // [R1]
         access_col_ff   <= gen_col;                             // [R14] [R24]
      end
   end

   // Pipe taps; two-bit taps stay inside the pipe even for reserved codes
   assign data_tap  = 2'(lat - LAT_ONE);                         // [R17]
   assign drive_tap = 2'(lat - LAT_ONE - LAT_ONE);               // [R18]

   // Read latency pipe: drive starts one cycle before data is valid
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_pipe_ff       <= '0;
         dq_drive_ff      <= 1'b0;
         rd_data_valid_ff <= 1'b0;
      end else begin
         rd_pipe_ff <= {rd_pipe_ff[LAT_DEPTH-2:0], burst_on_ff && !burst_wr_ff};
         dq_drive_ff      <= rd_pipe_ff[drive_tap];              // [R18]
         rd_data_valid_ff <= rd_pipe_ff[data_tap];               // [R17] [R18]
      end
   end
endmodule // sdram_cmd_front

// ### sdram_cmd_front_asserts.sv
// Purpose: Port-level checks of burst order, mode storage and read timing
// Assumes: One clock; bursts are never overlapped by a second column command
// Notes:   Column order is checked against the first column of each burst
`timescale 1ns/1ps
module sdram_cmd_front_asserts
(
   input logic                           core_clk,
   input logic                           rst_n,
   input sdram_cfg_pkg::cmd_bus_t        cmd_pins,
   input logic [sdram_cfg_pkg::BANK_W-1:0] access_bank_ff,
   input logic [sdram_cfg_pkg::ROW_W-1:0]  access_row_ff,
   input logic [sdram_cfg_pkg::COL_W-1:0]  access_col_ff,
   input logic                           access_valid_ff,
   input logic                           access_write_ff,
   input logic                           dq_drive_ff,
   input logic                           rd_data_valid_ff,
   input logic [sdram_cfg_pkg::MODE_W-1:0] mode_value_ff,
   input logic                           mode_valid_ff,
   input logic                           mode_reserved_ff,
   input logic                           init_done_ff
);
   import sdram_cfg_pkg::*;
   logic [3:0] since_load_ff;
   logic [9:0] run_ff;
   logic [8:0] first_col_ff;
   logic [2:0] bl;
   logic [8:0] msk;
   // Block mask; a whole-row burst uses every column bit
   assign bl  = mode_value_ff[2:0];
   assign msk = (bl == BL_ROW) ? 9'h1FF : (9'h001 << bl) - 9'h001;
   // Cycles since a load showed on the pins, saturating so it cannot wrap back
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) since_load_ff <= 4'hF;
      else if ({cmd_pins.cs_n, cmd_pins.ras_n, cmd_pins.cas_n, cmd_pins.we_n} == CMD_MODE_LOAD)
         since_load_ff <= 4'h0;
      else if (since_load_ff != 4'hF) since_load_ff <= since_load_ff + 4'h1;
   end
   // Index within the running burst and its first column
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         run_ff       <= 10'h000;
         first_col_ff <= 9'h000;
      end else begin
         run_ff <= access_valid_ff ? run_ff + 10'h001 : 10'h000;
         if (access_valid_ff && run_ff == 10'h000) first_col_ff <= access_col_ff;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_two_cols;
      access_valid_ff ##1 access_valid_ff;
   endsequence
   a_drive_leads_data: assert property ($rose(dq_drive_ff) |=> rd_data_valid_ff)
      else $error("data valid did not follow drive enable by one cycle");
   a_mode_only_load: assert property ($changed(mode_value_ff) |-> since_load_ff < 4'hC)
      else $error("stored mode changed without a load");
   a_stay_in_block: assert property (s_two_cols ##0 (bl inside {[1:3]}) |->
      (access_col_ff & ~msk) == ($past(access_col_ff) & ~msk))
      else $error("burst left its aligned block");
   a_column_order: assert property (access_valid_ff && run_ff != 10'h000 && bl != 3'h0 |->
      (access_col_ff & msk) == ((mode_value_ff[3] ? (first_col_ff ^ run_ff[8:0])
                                                  : (first_col_ff + run_ff[8:0])) & msk))
      else $error("burst column order wrong");
   a_burst_len_cap: assert property (access_valid_ff && bl != BL_ROW |->
      run_ff < (10'h001 << bl))
      else $error("burst longer than programmed");
   a_write_single: assert property (access_valid_ff && access_write_ff && mode_value_ff[9]
      |=> !access_valid_ff)
      else $error("write burst not single with write burst bit set");
   a_row_held: assert property (s_two_cols |-> $stable(access_bank_ff) && $stable(access_row_ff))
      else $error("bank or row moved inside a burst");
   a_access_needs_mode: assert property (access_valid_ff |-> mode_valid_ff && init_done_ff)
      else $error("access before mode load");
   a_reserved_flag: assert property (mode_valid_ff && mode_value_ff[8:7] != 2'h0 |->
      ##[0:1] mode_reserved_ff)
      else $error("reserved operating mode not flagged");
endmodule // sdram_cmd_front_asserts

bind sdram_cmd_front sdram_cmd_front_asserts u_sdram_cmd_front_asserts (.core_clk, .rst_n,
   .cmd_pins, .access_bank_ff, .access_row_ff, .access_col_ff, .access_valid_ff,
   .access_write_ff, .dq_drive_ff, .rd_data_valid_ff, .mode_value_ff, .mode_valid_ff,
   .mode_reserved_ff, .init_done_ff);

// ### ctrl_model.sv
// Purpose: Controller side model driving command pins
// Assumes: One issue strobe per command, only while busy is low
// Notes:   Command held four cycles then four idle cycles, to pass the pin filter
`timescale 1ns/1ps
module ctrl_model
(
   input  logic                    core_clk,
   input  logic                    rst_n,
   input  logic                    issue,
   input  sdram_cfg_pkg::cmd_bus_t req,
   output sdram_cfg_pkg::cmd_bus_t cmd_pins,
   output logic                    busy
);
   import sdram_cfg_pkg::*;
   logic [3:0] hold_ff;
   // Idle is a selected no-op; released address lines show the inverse of
   // the last value so nothing relies on a stale address
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_ff  <= 4'h0;
         cmd_pins <= {CMD_NOP, 2'h0, 13'h0000};
      end else if (issue) begin
         hold_ff  <= 4'h8;
         cmd_pins <= req;
      end else if (hold_ff != 4'h0) begin
         hold_ff <= hold_ff - 4'h1;
         if (hold_ff == 4'h5) cmd_pins <= {CMD_NOP, ~cmd_pins.bank, ~cmd_pins.addr};
      end
   end
   assign busy = (hold_ff != 4'h0);
endmodule // ctrl_model

// ### sdram_cmd_front_tb.sv
// Purpose: Self-checking bench for the DRAM command front end
// Assumes: Short power-up count; commands issued through the controller model
// Notes:   Columns are collected by a monitor and compared after each burst
`timescale 1ns/1ps
module sdram_cmd_front_tb;
   import sdram_cfg_pkg::*;
   localparam int PW = 20;
   logic        core_clk, rst_n, issue, busy, av_d, rv_d, wr_seen;
   cmd_bus_t    req, cmd_pins;
   logic [1:0]  access_bank_ff, lb, b;
   logic [12:0] access_row_ff, lr, r;
   logic [8:0]  access_col_ff, s;
   logic        access_valid_ff, access_write_ff, dq_drive_ff, rd_data_valid_ff;
   logic [11:0] mode_value_ff, mode;
   logic        mode_valid_ff, mode_reserved_ff, init_done_ff, seq_error_ff;
   logic [2:0]  cl;
   logic [8:0]  colq[$];
   int          fails, compares, cyc, t_acc, t_rd, seed;
   int          lat[4];

   sdram_cmd_front #(.PWRUP_CYCLES(PW)) u_sdram_cmd_front (.core_clk, .rst_n, .cmd_pins,
      .access_bank_ff, .access_row_ff, .access_col_ff, .access_valid_ff, .access_write_ff,
      .dq_drive_ff, .rd_data_valid_ff, .mode_value_ff, .mode_valid_ff, .mode_reserved_ff,
      .init_done_ff, .seq_error_ff);
   ctrl_model u_ctrl_model (.core_clk, .rst_n, .issue, .req, .cmd_pins, .busy);

   // 200 MHz clock
   initial core_clk = 1'b0;
   always #2.5 core_clk = ~core_clk;

   // Monitor: collect burst columns and edge times of first column and data
   always @(posedge core_clk) begin
      cyc  <= cyc + 1;
      av_d <= access_valid_ff;
      rv_d <= rd_data_valid_ff;
      if (access_valid_ff) begin
         colq.push_back(access_col_ff);
         lb      <= access_bank_ff;
         lr      <= access_row_ff;
         wr_seen <= access_write_ff;
      end
      if (access_valid_ff && !av_d) t_acc <= cyc;
      if (rd_data_valid_ff && !rv_d) t_rd <= cyc;
   end

   // Expected k-th column: upper bits from the start, lower bits wrap in block
   function automatic logic [8:0] exp_col(logic [8:0] st, logic [2:0] code, logic il, int k);
      logic [8:0] m;
      m = (code == BL_ROW) ? 9'h1FF : (9'h001 << code) - 9'h001;
      exp_col = (st & ~m) | ((il ? (st ^ k[8:0]) : (st + k[8:0])) & m);
   endfunction

   task automatic chk(string nm, logic [12:0] e, logic [12:0] v);
      compares++;
      if (v !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, v);
      end
   endtask

   // One command through the model; returns once its idle gap has passed
   task automatic cmd(cmd_t c, logic [1:0] bk, logic [12:0] a);
      @(posedge core_clk);
      req   <= {c, bk, a};
      issue <= 1'b1;
      @(posedge core_clk);
      issue <= 1'b0;
      @(posedge core_clk);
      for (int i = 0; i < 12 && busy !== 1'b0; i++) @(posedge core_clk);
   endtask

   task automatic setm(logic pre, logic [11:0] m);
      if (pre) cmd(CMD_PRECHARGE, 2'h0, 13'h0400);
      cmd(CMD_MODE_LOAD, 2'h0, {1'b0, m});
      chk("mode", {1'b0, m}, {1'b0, mode_value_ff});
   endtask

   task automatic burst(cmd_t c, int n);
      colq.delete();
      cmd(c, b, {4'h0, s});
      for (int i = 0; i < 60 && colq.size() < n; i++) @(posedge core_clk);
      repeat (10) @(posedge core_clk);
   endtask

   task automatic chk_cols(logic [2:0] code, logic il, int n);
      if (code != BL_ROW) chk("count", 13'(n), 13'(colq.size()));
      for (int k = 0; k < n; k++) chk("col", {4'h0, exp_col(s, code, il, k)}, {4'h0, colq[k]});
      chk("bank", {11'h000, b}, {11'h000, lb});
      chk("row", r, lr);
   endtask

   task automatic end_sim();
      if (fails == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Watchdog: the sequence needs under 1000 cycles; allow 20000 cycles
   initial begin
      #100000;
      fails++;
      end_sim();
   end

   initial begin
      rst_n = 1'b0;
      issue = 1'b0;
      req   = '0;
      fails = 0;
      compares = 0;
      cyc   = 0;
      seed  = $urandom(36963);
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      chk("mode_valid", 13'h0000, {12'h000, mode_valid_ff});
      repeat (PW + 2) @(posedge core_clk);
      cmd(CMD_PRECHARGE, 2'h0, 13'h0400);
      cmd(CMD_REFRESH, 2'h0, 13'h0000);
      cmd(CMD_MODE_LOAD, 2'h0, 13'h0000);
      cmd(CMD_REFRESH, 2'h0, 13'h0000);
      chk("init_done", 13'h0000, {12'h000, init_done_ff});
      // Every fixed length and order, both latencies, random bank and row, random start except 1FF in the last pass
      for (int i = 0; i < 8; i++) begin
         cl   = i[0] ? CL_THREE : CL_TWO;
         mode = {2'h0, 1'b0, 2'h0, cl, i[2], i[1:0] == 2'h0 ? BL_ONE : {1'b0, i[1:0]}};
         setm(i > 0, mode);
         chk("init_done", 13'h0001, {12'h000, init_done_ff});
         chk("reserved", 13'h0000, {12'h000, mode_reserved_ff});
         b = 2'($urandom);
         r = 13'($urandom);
         s = (i == 7) ? 9'h1FF : 9'($urandom);
         cmd(CMD_ROW_OPEN, b, r);
         burst(CMD_READ, 1 << i[1:0]);
         chk_cols({1'b0, i[1:0]}, i[2], 1 << i[1:0]);
         chk("latency", 13'(cl), 13'(t_rd - t_acc));
         lat[cl] = t_rd - t_acc;
      end
      chk("latency step", 13'(lat[2] + 1), 13'(lat[3]));
      // Whole-row burst wraps past the last column, then is stopped
      setm(1'b1, 12'h027);
      cmd(CMD_ROW_OPEN, b, r);
      s = 9'h1FE;
      burst(CMD_READ, 4);
      cmd(CMD_STOP, b, 13'h0000);
      chk_cols(BL_ROW, 1'b0, 4);
      chk("stopped", 13'h0000, {12'h000, access_valid_ff});
      // Write burst bit: writes single, reads keep their length
      setm(1'b1, 12'h223);
      cmd(CMD_ROW_OPEN, b, r);
      burst(CMD_WRITE, 1);
      chk_cols(BL_ONE, 1'b0, 1);
      chk("write", 13'h0001, {12'h000, wr_seen});
      burst(CMD_READ, 8);
      chk_cols(BL_EIGHT, 1'b0, 8);
      // Reserved operating mode, read to closed bank, load with a row open
      setm(1'b1, 12'h0A3);
      chk("reserved", 13'h0001, {12'h000, mode_reserved_ff});
      burst(CMD_READ, 1);
      chk("closed read", 13'h0000, 13'(colq.size()));
      chk("seq_error", 13'h0000, {12'h000, seq_error_ff});
      cmd(CMD_ROW_OPEN, b, r);
      cmd(CMD_MODE_LOAD, 2'h0, 13'h0023);
      chk("seq_error", 13'h0001, {12'h000, seq_error_ff});
      chk("mode kept", 13'h00A3, {1'b0, mode_value_ff});
      end_sim();
   end
endmodule // sdram_cmd_front_tb
